/* File: tb.sv */
`timescale 1ns/100ps
module tb;
   import vmc_pkg::*;
   localparam int STAB = 4; // Short delay keeps the run brief
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0, vcc = 8'h80, ext = 8'h00;
   logic [31:0] pwdata = 0, prdata;
   logic        pready, pslverr, c1, c2, c2x, nmi_req, irq;
   logic [1:0]  event_link, mon_reset, lvl_hi;
   logic [3:0]  lvl_lo;
   int          nmi_cnt, ev_cnt, mismatches = 0, checks = 0;
   always #20 pclk = ~pclk;
   vmc_top #(.VARIANT_B(1'b1), .STAB_CYCLES(STAB)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ch1_cmp_supply(c1), .ch2_cmp_supply(c2), .ch2_cmp_ext(c2x), .nmi_req(nmi_req),
      .irq(irq), .event_link(event_link), .mon_reset(mon_reset),
      .ch1_threshold_sel_out(lvl_hi), .ch1_threshold_code(lvl_lo));
   // Threshold of ch1 at zero keeps ch1 quiet while ch2 is exercised
   vmc_far_model i_far (
      .pclk(pclk), .presetn(presetn), .vcc(vcc), .ext_pin(ext), .th1(8'h00),
      .th2(8'h40), .nmi_req(nmi_req), .event_link(event_link), .ch1_cmp(c1),
      .ch2_cmp(c2), .ch2_ext(c2x), .nmi_cnt(nmi_cnt), .ev_cnt(ev_cnt));
   // ==========================================================
   // Shared helpers
   task automatic close_out;
      if (mismatches == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Request held until pready is seen high at a rising edge; answer taken there
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q & m, exp);
   endtask : rd
   task automatic lvl(input logic [7:0] v);
      @(posedge pclk);
      vcc <= v;
      repeat (10) @(posedge pclk);
   endtask : lvl
   task automatic hi_len(output int n);
      int w;
      w = 0;
      n = 0;
      while (mon_reset[1] !== 1'b1 && w < 20) begin @(negedge pclk); w++; end
      while (mon_reset[1] === 1'b1 && n < 200) begin @(negedge pclk); n++; end
   endtask : hi_len
   // ==========================================================
   // Scenarios
   task automatic t_regs;
      logic [7:0] adr [7] = '{ADDR_MON1_CTRL1, ADDR_MON2_CTRL1, ADDR_CMP_CTRL,
                              ADDR_LVL_SEL, ADDR_MON1_CTRL0, ADDR_MON2_CTRL0, ADDR_IRQ_MASK};
      logic [31:0] q;
      logic e;
      foreach (adr[i]) rd(adr[i], {24'h0, CTRL_RESET}, 32'hff);
      rd(ADDR_MON2_STATUS, 32'h1, 32'h1);
      rd(ADDR_MON1_STATUS, 32'h1, 32'h3);
      wr(ADDR_LVL_SEL, 32'hfd);
      rd(ADDR_LVL_SEL, 32'h3d, 32'hff);
      chk({28'h0, lvl_lo}, 32'hd);
      chk({30'h0, lvl_hi}, 32'h3);
      apb(1'b0, 8'h40, 32'h0, q, e);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
   endtask : t_regs
   // Only the three legal codes are ever written to the condition field
   task automatic t_cond;
      int n0, e0, x;
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_MON2_CTRL1, 32'h80 | (32'(i) << CTRL1_COND_LSB));
         n0 = nmi_cnt;
         e0 = ev_cnt;
         lvl(8'h10);
         lvl(8'h80);
         x = (i == 2) ? 2 : 1;
         chk(32'(nmi_cnt - n0), 32'(x));
         chk(32'(ev_cnt - e0), 32'(x));
         rd(ADDR_MON2_STATUS, 32'h3, 32'h3);
         wr(ADDR_MON2_STATUS, 32'h0);
         rd(ADDR_MON2_STATUS, 32'h1, 32'h3);
      end
   endtask : t_cond
   task automatic t_irq;
      int n0;
      wr(ADDR_IRQ_MASK, 32'hff);
      wr(ADDR_MON2_CTRL1, 32'h81 | (32'(COND_BOTH) << CTRL1_COND_LSB));
      n0 = nmi_cnt;
      lvl(8'h10);
      chk({31'h0, irq}, 32'h1);
      chk(32'(nmi_cnt - n0), 32'h0);
      rd(ADDR_IRQ_STATUS, 32'h2, 32'h3);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      wr(ADDR_IRQ_MASK, 32'h0);
      lvl(8'h80);
      chk({31'h0, irq}, 32'h0);
      wr(ADDR_IRQ_MASK, 32'hff);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      rd(ADDR_IRQ_STATUS, 32'h2, 32'h3);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      wr(ADDR_MON2_STATUS, 32'h0);
   endtask : t_irq
   task automatic t_mon;
      wr(ADDR_MON2_CTRL1, 32'h0);
      lvl(8'h10);
      rd(ADDR_MON2_STATUS, 32'h1, 32'h1);
      wr(ADDR_MON2_CTRL1, 32'h80);
      lvl(8'h10);
      rd(ADDR_MON2_STATUS, 32'h0, 32'h1);
      lvl(8'h80);
      rd(ADDR_MON2_STATUS, 32'h1, 32'h1);
      wr(ADDR_CMP_CTRL, 32'h1);
      lvl(8'h80);
      rd(ADDR_MON2_STATUS, 32'h0, 32'h1);
      ext <= 8'h80;
      lvl(8'h80);
      rd(ADDR_MON2_STATUS, 32'h1, 32'h1);
      wr(ADDR_CMP_CTRL, 32'h0);
   endtask : t_mon
   task automatic t_rst;
      int n;
      wr(ADDR_MON2_CTRL0, 32'h1);
      lvl(8'h10);
      repeat (30) @(posedge pclk);
      chk({31'h0, mon_reset[1]}, 32'h1);
      // Rise at this edge; two sync stages, the filter flop, the hold edge
      // and the output flop put the release STAB + 5 edges later
      @(posedge pclk);
      vcc <= 8'h80;
      n = 0;
      while (mon_reset[1] === 1'b1 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      chk(32'(n), 32'(STAB + 5));
      wr(ADDR_MON2_CTRL0, 32'h41);
      @(posedge pclk);
      vcc <= 8'h10;
      hi_len(n);
      chk(32'(n >= STAB && n <= STAB + 2), 32'h1);
      // Supply still low: once released, the reset must stay released
      repeat (STAB + 2) @(posedge pclk);
      chk({31'h0, mon_reset[1]}, 32'h0);
      lvl(8'h80);
      wr(ADDR_MON2_CTRL0, 32'h0);
   endtask : t_rst
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      t_regs();
      t_cond();
      t_irq();
      t_mon();
      t_rst();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      close_out();
   end
endmodule : tb

/* File: vmc_far_model.sv */
`timescale 1ns/100ps
// ==========================================================
// Far side: supply comparators and interrupt controller
module vmc_far_model (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Analog levels, arbitrary units
   input  wire logic [7:0] vcc,
   input  wire logic [7:0] ext_pin,
   input  wire logic [7:0] th1,
   input  wire logic [7:0] th2,
   // Requests from the block
   input  wire logic       nmi_req,
   input  wire logic [1:0] event_link,
   // Comparator outputs, 1 = at or above
   output logic            ch1_cmp,
   output logic            ch2_cmp,
   output logic            ch2_ext,
   // Request tallies
   output int              nmi_cnt,
   output int              ev_cnt
);
   // Ideal comparators, no hysteresis, so every crossing is clean
   assign ch1_cmp = (vcc >= th1);
   assign ch2_cmp = (vcc >= th2);
   assign ch2_ext = (ext_pin >= th2);
   // ==========================================================
   // Controller side: tally one-cycle request pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_cnt <= 0;
         ev_cnt  <= 0;
      end else begin
         if (nmi_req === 1'b1) nmi_cnt <= nmi_cnt + 1;
         if (event_link[1] === 1'b1) ev_cnt <= ev_cnt + 1;
      end
   end
endmodule : vmc_far_model

/* File: vmc_filter.sv */
`timescale 1ns/100ps
// Sampled filter: level accepted after two matching samples.
module vmc_filter
   import vmc_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Configuration and data
   input  wire vmc_pkg::vmc_ch_cfg_t cfg,
   input  wire logic        cmp_sync,
   // Result
   output vmc_pkg::vmc_ch_out_t res
);
   import vmc_pkg::*;
   // ==========================================================
   // State
   typedef struct packed {
      logic [2:0] div_cnt;   // sample divider
      logic       s_prev;    // last sample
      logic       level;     // accepted level
      logic       lvl_d;     // level one cycle earlier
   } vmc_flt_st_t;
   vmc_flt_st_t st_r, st_nxt;
   logic        tick;        // sample strobe
   // ==========================================================
   // Divider select: 1, 2, 4 or 8 clocks between samples
   always_comb begin
      tick = (st_r.div_cnt & ((3'h1 << cfg.div_sel) - 3'h1)) == 3'h0;
   end
   // Next state
   always_comb begin
      st_nxt         = st_r;
      st_nxt.div_cnt = st_r.div_cnt + 3'h1;
      st_nxt.lvl_d   = st_r.level;
      if (cfg.bypass) begin
         // Filter bypassed, follow comparator directly
         st_nxt.level  = cmp_sync;
         st_nxt.s_prev = cmp_sync;
      end else if (tick) begin
         st_nxt.s_prev = cmp_sync;
         if (cmp_sync == st_r.s_prev) begin
            st_nxt.level = cmp_sync;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Assume supply good after reset
         st_r <= '{div_cnt: 3'h0, s_prev: 1'b1, level: 1'b1, lvl_d: 1'b1};
      end else begin
         st_r <= st_nxt;
      end
   end
   // Crossing and condition decode
   always_comb begin
      res.level = st_r.level;
      res.rise  = st_r.level & ~st_r.lvl_d;
      res.fall  = ~st_r.level & st_r.lvl_d;
      case (cfg.cond)
         COND_RISE: res.event_hit = res.rise;
         COND_FALL: res.event_hit = res.fall;
         COND_BOTH: res.event_hit = res.rise | res.fall;
         default:   res.event_hit = 1'b0;
      endcase
   end
endmodule : vmc_filter

/* File: vmc_pkg.sv */
package vmc_pkg;
   // ==========================================================
   // Register byte addresses (APB, one word each)
   localparam logic [7:0] ADDR_MON1_CTRL1  = 8'h00;
   localparam logic [7:0] ADDR_MON2_CTRL1  = 8'h04;
   localparam logic [7:0] ADDR_MON2_STATUS = 8'h08;
   localparam logic [7:0] ADDR_CMP_CTRL    = 8'h0c;
   localparam logic [7:0] ADDR_LVL_SEL     = 8'h10;
   localparam logic [7:0] ADDR_MON1_CTRL0  = 8'h14;
   localparam logic [7:0] ADDR_MON2_CTRL0  = 8'h18;
   localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h1c;
   localparam logic [7:0] ADDR_IRQ_MASK    = 8'h20;
   localparam logic [7:0] ADDR_MON1_STATUS = 8'h24;
   // ==========================================================
   // Field positions
   localparam int CTRL1_IRQ_TYPE_BIT = 0;    // 1 = maskable, 0 = non-maskable
   localparam int CTRL1_COND_LSB     = 1;    // crossing condition, 2 bits
   localparam int CTRL0_RST_EN_BIT   = 0;
   localparam int CTRL0_BYPASS_BIT   = 1;
   localparam int CTRL0_DIV_LSB      = 4;
   localparam int CTRL0_RN_BIT       = 6;
   localparam int LVL1_LSB           = 0;
   localparam int LVL2_LSB           = 4;
   localparam int LVL2_W_A           = 4;    // bits 7..4 in variant A
   localparam int LVL2_W_B           = 2;    // bits 5..4 in variant B
   localparam int STAT_MON_BIT       = 0;
   localparam int STAT_DET_BIT       = 1;
   // ==========================================================
   // Reset values and timing
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int STAB_CYCLES_DEF    = 16;   // stabilization delay in clocks
   // Crossing condition encodings
   localparam logic [1:0] COND_RISE = 2'h0;
   localparam logic [1:0] COND_FALL = 2'h1;
   localparam logic [1:0] COND_BOTH = 2'h2;
   // Per-channel configuration carried to the channel module
   typedef struct packed {
      logic       bypass;
      logic [1:0] div_sel;
      logic [1:0] cond;
   } vmc_ch_cfg_t;
   // Per-channel results
   typedef struct packed {
      logic level;    // filtered level, 1 = at/above threshold
      logic rise;     // one-cycle crossing pulses
      logic fall;
      logic event_hit;
   } vmc_ch_out_t;
endpackage : vmc_pkg

/* File: vmc_stab.sv */
`timescale 1ns/100ps
// Reset hold and release counter for one channel.
module vmc_stab
   import vmc_pkg::*;
#(
   parameter int STAB_CYCLES = STAB_CYCLES_DEF
)(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Control
   input  wire logic rst_en,
   input  wire logic release_sel,
   input  wire logic level,
   // Result
   output logic      rst_out
);
   import vmc_pkg::*;
   localparam logic [15:0] LAST = 16'(STAB_CYCLES - 1);
   typedef struct packed {
      logic        active;
      logic [15:0] cnt;
      logic        lvl_d;   // level one cycle earlier, for drop detection
   } vmc_stab_st_t;
   vmc_stab_st_t st_r, st_nxt;
   // ==========================================================
   // Assert while low; release STAB_CYCLES after the chosen start
   always_comb begin
      st_nxt       = st_r;
      st_nxt.lvl_d = level;
      if (!rst_en) begin
         st_nxt.active = 1'b0;
         st_nxt.cnt    = '0;
      end else if (!st_r.active) begin
         // After-assertion mode starts only on a new drop, so a supply that
         // stays low does not retrigger the reset once it has been released
         if (!level && (!release_sel || st_r.lvl_d)) begin
            st_nxt.active = 1'b1;
            st_nxt.cnt    = '0;
         end
      end else if (!level && !release_sel) begin
         st_nxt.cnt = '0;                              // hold while below
      end else if (st_r.cnt == LAST) begin
         st_nxt.active = 1'b0;
      end else begin
         st_nxt.cnt = st_r.cnt + 16'h1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '{active: 1'b0, cnt: 16'h0, lvl_d: 1'b1};
      end else begin
         st_r <= st_nxt;
      end
   end
   assign rst_out = st_r.active;
endmodule : vmc_stab

/* File: vmc_top.sv */
`timescale 1ns/100ps
// Function
// - Variant B: per-channel NMI or maskable select
// - Variant A: requests always non-maskable
// - Ch2 condition: 00 rise, 01 fall, 10 both
// - Variant B: condition also gates event output
// - Monitor flag 0 below, 1 above/disabled
// - Variant B: ch2 source supply or external pin
// - Ch2 level field width per variant
// - Variant A: filter bypass bit per channel
// - Variant A: filter samples at div 1/2/4/8, two matches
// - Release select: after rise or after assertion
// - Variant B: event output per channel crossing
// - Sticky detection flag on any crossing of an enabled channel
// - Release after rise: hold reset while below threshold
module vmc_top
   import vmc_pkg::*;
#(
   parameter bit VARIANT_B   = 1'b1,
   parameter int STAB_CYCLES = STAB_CYCLES_DEF
)(
   // APB clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Analog comparator outputs (1 = at/above threshold)
   input  wire logic        ch1_cmp_supply,
   input  wire logic        ch2_cmp_supply,
   input  wire logic        ch2_cmp_ext,
   // Requests and threshold level outputs
   output logic             nmi_req,
   output logic             irq,
   output logic [1:0]       event_link,
   output logic [1:0]       mon_reset,
   output logic [1:0]       ch1_threshold_sel_out,
   output logic [3:0]       ch1_threshold_code
);
   import vmc_pkg::*;
   // ==========================================================
   // Register state
   typedef struct packed {
      logic [7:0]  ctrl1_1;     // monitor1_control_1
      logic [7:0]  ctrl1_2;     // monitor2_control_1
      logic [7:0]  ctrl0_1;     // monitor1_control_0
      logic [7:0]  ctrl0_2;     // monitor2_control_0
      logic [7:0]  cmp_ctrl;    // comparison_input_control
      logic [7:0]  lvl;         // detection_level_select
      logic [1:0]  det;         // sticky crossing flags
      logic [1:0]  irq_stat;    // sticky interrupt status
      logic [1:0]  irq_mask;
      logic        irq;
      logic        nmi;
      logic [1:0]  evt;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic [1:0]  c1_s;        // synchronizer stages
      logic [1:0]  c2_s;
      logic [1:0]  cx_s;
      logic [1:0]  rst;
   } vmc_st_t;
   vmc_st_t st_r, st_nxt;
   vmc_ch_cfg_t cfg [2];
   vmc_ch_out_t res [2];
   logic [1:0]  cmp_in;
   logic [1:0]  rst_raw;
   logic [1:0]  ch_en;
   logic [1:0]  mon_flag;
   logic [1:0]  hit;
   logic [1:0]  irq_type;
   logic        rd_en;
   logic        wr_en;
   logic [31:0] rdata;
   logic        unmapped;
   // ==========================================================
   // Address validity, used by read and write paths
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a <= ADDR_MON1_STATUS) && (a[1:0] == 2'h0);
   endfunction : addr_ok
   // ==========================================================
   // Channel source selection; sync stage 2 is the only reader of stage 1
   always_comb begin
      cmp_in[0] = st_r.c1_s[1];
      // External pin only exists in variant B
      if (VARIANT_B && st_r.cmp_ctrl[0]) begin
         cmp_in[1] = st_r.cx_s[1];
      end else begin
         cmp_in[1] = st_r.c2_s[1];
      end
      ch_en[0] = st_r.ctrl0_1[CTRL0_RST_EN_BIT] | st_r.ctrl1_1[7];
      ch_en[1] = st_r.ctrl0_2[CTRL0_RST_EN_BIT] | st_r.ctrl1_2[7];
      // Maskable only when variant B selects it
      irq_type[0] = VARIANT_B & st_r.ctrl1_1[CTRL1_IRQ_TYPE_BIT];
      irq_type[1] = VARIANT_B & st_r.ctrl1_2[CTRL1_IRQ_TYPE_BIT];
   end
   // Per-channel config; variant B has no filter so bypass is forced
   always_comb begin
      cfg[0].bypass  = VARIANT_B | st_r.ctrl0_1[CTRL0_BYPASS_BIT];
      cfg[0].div_sel = st_r.ctrl0_1[CTRL0_DIV_LSB +: 2];
      cfg[0].cond    = st_r.ctrl1_1[CTRL1_COND_LSB +: 2];
      cfg[1].bypass  = VARIANT_B | st_r.ctrl0_2[CTRL0_BYPASS_BIT];
      cfg[1].div_sel = st_r.ctrl0_2[CTRL0_DIV_LSB +: 2];
      cfg[1].cond    = st_r.ctrl1_2[CTRL1_COND_LSB +: 2];
   end
   // ==========================================================
   // Filter and reset timing per channel
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ch
         vmc_filter u_flt (
            .pclk     (pclk),
            .presetn  (presetn),
            .cfg      (cfg[g]),
            .cmp_sync (cmp_in[g]),
            .res      (res[g])
         );
         vmc_stab #(.STAB_CYCLES(STAB_CYCLES)) u_stab (
            .pclk        (pclk),
            .presetn     (presetn),
            .rst_en      (g == 0 ? st_r.ctrl0_1[CTRL0_RST_EN_BIT]
                                 : st_r.ctrl0_2[CTRL0_RST_EN_BIT]),
            .release_sel (g == 0 ? st_r.ctrl0_1[CTRL0_RN_BIT]
                                 : st_r.ctrl0_2[CTRL0_RN_BIT]),
            .level       (res[g].level),
            .rst_out     (rst_raw[g])
         );
         // Monitor reads 1 when the channel is disabled
         assign mon_flag[g] = res[g].level | ~ch_en[g];
         assign hit[g]      = res[g].event_hit & ch_en[g];
      end
   endgenerate
   // ==========================================================
   // Read mux
   always_comb begin
      rdata = 32'h0;
      if (paddr == ADDR_MON1_CTRL1) begin
         rdata[7:0] = st_r.ctrl1_1;
      end else if (paddr == ADDR_MON2_CTRL1) begin
         rdata[7:0] = st_r.ctrl1_2;
      end else if (paddr == ADDR_MON2_STATUS) begin
         rdata[STAT_MON_BIT] = mon_flag[1];
         rdata[STAT_DET_BIT] = st_r.det[1];
      end else if (paddr == ADDR_CMP_CTRL) begin
         rdata[7:0] = st_r.cmp_ctrl;
      end else if (paddr == ADDR_LVL_SEL) begin
         rdata[7:0] = st_r.lvl;
      end else if (paddr == ADDR_MON1_CTRL0) begin
         rdata[7:0] = st_r.ctrl0_1;
      end else if (paddr == ADDR_MON2_CTRL0) begin
         rdata[7:0] = st_r.ctrl0_2;
      end else if (paddr == ADDR_IRQ_STATUS) begin
         rdata[1:0] = st_r.irq_stat;
      end else if (paddr == ADDR_IRQ_MASK) begin
         rdata[1:0] = st_r.irq_mask;
      end else if (paddr == ADDR_MON1_STATUS) begin
         rdata[STAT_MON_BIT] = mon_flag[0];
         rdata[STAT_DET_BIT] = st_r.det[0];
      end
   end
   // ==========================================================
   // Next state: APB, flags, requests
   always_comb begin
      st_nxt         = st_r;
      unmapped       = ~addr_ok(paddr);
      // Access phase completes one cycle after it is seen; one wait state
      rd_en          = psel & penable & ~pwrite & ~st_r.pready;
      wr_en          = psel & penable & pwrite & ~st_r.pready;
      st_nxt.pready  = psel & penable & ~st_r.pready;
      st_nxt.pslverr = psel & penable & ~st_r.pready & unmapped;
      st_nxt.c1_s    = {st_r.c1_s[0], ch1_cmp_supply};
      st_nxt.c2_s    = {st_r.c2_s[0], ch2_cmp_supply};
      st_nxt.cx_s    = {st_r.cx_s[0], ch2_cmp_ext};
      if (rd_en) begin
         st_nxt.prdata = rdata;
      end
      if (wr_en && !unmapped) begin
         if (paddr == ADDR_MON1_CTRL1) begin
            st_nxt.ctrl1_1 = pwdata[7:0];
         end else if (paddr == ADDR_MON2_CTRL1) begin
            st_nxt.ctrl1_2 = pwdata[7:0];
         end else if (paddr == ADDR_CMP_CTRL) begin
            st_nxt.cmp_ctrl = {7'h0, pwdata[0] & VARIANT_B};
         end else if (paddr == ADDR_LVL_SEL) begin
            // Ch2 field is 2 bits wide in variant B
            st_nxt.lvl = VARIANT_B ? {2'h0, pwdata[5:4], pwdata[3:0]}
                                   : pwdata[7:0];
         end else if (paddr == ADDR_MON1_CTRL0) begin
            st_nxt.ctrl0_1 = pwdata[7:0];
         end else if (paddr == ADDR_MON2_CTRL0) begin
            st_nxt.ctrl0_2 = pwdata[7:0];
         end else if (paddr == ADDR_IRQ_MASK) begin
            st_nxt.irq_mask = pwdata[1:0];
         end else if (paddr == ADDR_MON2_STATUS) begin
            // Writing 0 clears detection flag
            if (!pwdata[STAT_DET_BIT]) st_nxt.det[1] = 1'b0;
         end else if (paddr == ADDR_MON1_STATUS) begin
            if (!pwdata[STAT_DET_BIT]) st_nxt.det[0] = 1'b0;
         end
      end
      // Read clears status; set after clear so a coincident event wins
      if (rd_en && paddr == ADDR_IRQ_STATUS) begin
         st_nxt.irq_stat = 2'h0;
      end
      for (int i = 0; i < 2; i++) begin
         if ((res[i].rise | res[i].fall) & ch_en[i]) begin
            st_nxt.det[i] = 1'b1;
         end
         if (hit[i]) begin
            st_nxt.irq_stat[i] = 1'b1;
         end
      end
      // Non-maskable route as a pulse; maskable via status and mask
      st_nxt.nmi = |(hit & ~irq_type);
      st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask & irq_type);
      st_nxt.evt = VARIANT_B ? hit : 2'h0;
      st_nxt.rst = rst_raw;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r      <= '0;
         st_r.c1_s <= 2'h3;
         st_r.c2_s <= 2'h3;
         st_r.cx_s <= 2'h3;
      end else begin
         st_r <= st_nxt;
      end
   end
   // ==========================================================
   // Outputs straight from flip-flops
   assign prdata                = st_r.prdata;
   assign pready                = st_r.pready;
   assign pslverr               = st_r.pslverr;
   assign nmi_req               = st_r.nmi;
   assign irq                   = st_r.irq;
   assign event_link            = st_r.evt;
   assign mon_reset             = st_r.rst;
   assign ch1_threshold_code    = st_r.lvl[LVL1_LSB +: 4];
   assign ch1_threshold_sel_out = st_r.lvl[LVL2_LSB +: LVL2_W_B];
   // ==========================================================
   // Assertions
   property p_evt_variant;
      @(posedge pclk) disable iff (!presetn)
         !VARIANT_B |-> event_link == 2'h0;
   endproperty
   a_evt_variant: assert property (p_evt_variant) else $error("event in A");
   property p_nmi_only_a;
      @(posedge pclk) disable iff (!presetn)
         !VARIANT_B |-> !irq;
   endproperty
   a_nmi_only_a: assert property (p_nmi_only_a) else $error("irq in A");
   property p_det_set;
      @(posedge pclk) disable iff (!presetn)
         ((res[1].rise | res[1].fall) & ch_en[1]) |=> st_r.det[1];
   endproperty
   a_det_set: assert property (p_det_set) else $error("det not set");
   property p_mon_dis;
      @(posedge pclk) disable iff (!presetn)
         !ch_en[1] |-> mon_flag[1];
   endproperty
   a_mon_dis: assert property (p_mon_dis) else $error("monitor flag");
   property p_rise_hit;
      @(posedge pclk) disable iff (!presetn)
         (cfg[1].cond == COND_FALL && ch_en[1]) |-> !(hit[1] && res[1].rise);
   endproperty
   a_rise_hit: assert property (p_rise_hit) else $error("cond mismatch");
   property p_evt_hit;
      @(posedge pclk) disable iff (!presetn)
         (VARIANT_B && hit[1]) |=> event_link[1];
   endproperty
   a_evt_hit: assert property (p_evt_hit) else $error("no event");
   property p_mask_route;
      @(posedge pclk) disable iff (!presetn)
         (hit[1] && irq_type[1]) |=> !nmi_req || $past(hit[0]);
   endproperty
   a_mask_route: assert property (p_mask_route) else $error("nmi route");
   property p_rst_hold;
      @(posedge pclk) disable iff (!presetn)
         (rst_raw[1]) |=> mon_reset[1];
   endproperty
   a_rst_hold: assert property (p_rst_hold) else $error("reset lost");
   property p_pready;
      @(posedge pclk) disable iff (!presetn)
         (psel && penable && !pready) |=> pready;
   endproperty
   a_pready: assert property (p_pready) else $error("no pready");
   c_nmi: cover property (@(posedge pclk) disable iff (!presetn) nmi_req);
   c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
   c_rst: cover property (@(posedge pclk) disable iff (!presetn) mon_reset[1]);
endmodule : vmc_top
